/* File: hw/ebi_pkg.sv */
// What this block does
// - Space 3 bus width follows the width pin: low gives 16 bits, high gives 8.
// - While the reset input is low the block stays in its reset state.
// - Separate bus drives A0..A22 true, A23 inverted; high data lane only for 16 bits.
// - Multiplexed bus puts low (and middle) address byte on data lines, then data.
// - Address latch strobe marks when the shared lines carry the address.
// - Four active-low space selects, one per external space, asserted on access.
// - Two write strobe styles, split byte strobes or single strobe with byte enable.
// - Split style on 16 bits: low strobe writes even, high strobe writes odd.
// - Split style odd-address write on 16 bits drives the high-byte strobe low.
// - Both styles read external data while the read strobe is low.
// - Single style writes with strobe low; upper-byte enable low on odd or word access on 16 bits.
// - While hold request is low the block enters and stays in hold.
// - Hold acknowledge is low exactly while in hold.
// - Ready low stretches the access with wait states for as long as it stays low.
// - Clock pin carries bus clock, or fC, f8 or f32 as selected.
//
// Purpose: Shared constants for the external bus interface.
// Assumes: Bus clock is the system clock divided by two.
// Notes: None.
package ebi_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int DIV_W = 5;
    localparam int DIV_BCLK_BIT = 0;
    localparam int DIV_F8_BIT = 2;
    localparam int DIV_F32_BIT = 4;
    localparam logic [1:0] CLKSEL_BCLK = 2'h0;
    localparam logic [1:0] CLKSEL_FC = 2'h1;
    localparam logic [1:0] CLKSEL_F8 = 2'h2;
    localparam logic [1:0] CLKSEL_F32 = 2'h3;
    localparam logic [1:0] SPACE_BYTE_PIN = 2'h3;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_STROBE, S_END, S_HOLD} ebi_state_t;
endpackage : ebi_pkg

/* File: hw/ebi_top.sv */
// Purpose: External memory bus interface, address/data/strobe/select pin logic.
// Assumes: Pin inputs are asynchronous; request port is on I_CLK.
// Notes: Hold is only granted between accesses.
`timescale 1ns/1ns
module ebi_top
    import ebi_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_REQ_VALID,
    input wire logic I_REQ_WRITE,
    input wire logic I_REQ_WORD,
    input wire logic [1:0] I_REQ_SPACE,
    input wire logic [ADDR_W-1:0] I_REQ_ADDR,
    input wire logic [DATA_W-1:0] I_REQ_WDATA,
    output logic O_REQ_READY,
    output logic [DATA_W-1:0] O_RDATA,
    output logic O_RDATA_VALID,
    input wire logic I_MUX_BUS,
    input wire logic I_SINGLE_STROBE,
    input wire logic [1:0] I_CLK_OUT_SEL,
    input wire logic I_WIDTH_SEL,
    input wire logic I_BOOT_MODE_STRAP,
    output logic O_MICROPROC_MODE,
    input wire logic I_FC_CLK,
    input wire logic I_HOLD_N,
    input wire logic I_READY_N,
    input wire logic [DATA_W-1:0] I_DATA,
    output logic [DATA_W-1:0] O_DATA,
    output logic O_DATA_LO_OE,
    output logic O_DATA_HI_OE,
    output logic [ADDR_W-1:0] O_ADDR,
    output logic O_ADDR_OE,
    output logic [3:0] O_SPACE_SELECT_N,
    output logic O_ALE,
    output logic O_RD_N,
    output logic O_LOW_BYTE_WRITE_N,
    output logic O_HIGH_BYTE_WRITE_N,
    output logic O_CTRL_OE,
    output logic O_BUS_GRANT_ACK_N,
    output logic O_DIVIDED_CLOCK_OUT
);

////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ebi_state_t st;
        logic [1:0] hold_sy;
        logic [1:0] rdy_sy;
        logic [1:0] width_sy;
        logic [1:0] strap_sy;
        logic [1:0] fc_sy;
        logic [DATA_W-1:0] din_m;
        logic [DATA_W-1:0] din;
        logic [DIV_W-1:0] div;
        logic strap_done;
        logic mode;
        logic write;
        logic wide;
        logic bus16;
        logic [1:0] space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic clk_out;
    } ebi_regs_t;

    ebi_regs_t r;
    ebi_regs_t next_r;
    logic tick;
    logic accept;
    logic odd;
    logic hold_req;
    logic rdy_low;

    assign tick = r.div[DIV_BCLK_BIT];
    assign hold_req = !r.hold_sy[1];
    assign rdy_low = !r.rdy_sy[1];
    assign odd = r.addr[0];
    // Hold pending blocks new accesses so the bus can be surrendered
    // Take only on a bus tick, so every access shows a full address latch pulse
    assign O_REQ_READY = (r.st == S_IDLE) && !hold_req && r.strap_done && tick;
    assign accept = I_REQ_VALID && O_REQ_READY;

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.hold_sy = {r.hold_sy[0], I_HOLD_N};
        next_r.rdy_sy = {r.rdy_sy[0], I_READY_N};
        next_r.width_sy = {r.width_sy[0], I_WIDTH_SEL};
        next_r.strap_sy = {r.strap_sy[0], I_BOOT_MODE_STRAP};
        next_r.fc_sy = {r.fc_sy[0], I_FC_CLK};
        next_r.din_m = I_DATA;
        next_r.din = r.din_m;
        next_r.div = r.div + 5'h01;
        next_r.rvalid = 1'b0;
        // Strap caught once, after the synchroniser has filled
        if (!r.strap_done && r.div[1]) begin
            next_r.strap_done = 1'b1;
            next_r.mode = r.strap_sy[1];
        end
        case (I_CLK_OUT_SEL)
            CLKSEL_BCLK: next_r.clk_out = r.div[DIV_BCLK_BIT];
            CLKSEL_FC: next_r.clk_out = r.fc_sy[1];
            CLKSEL_F8: next_r.clk_out = r.div[DIV_F8_BIT];
            CLKSEL_F32: next_r.clk_out = r.div[DIV_F32_BIT];
            default: next_r.clk_out = 1'b0;
        endcase
        case (r.st)
            S_IDLE: begin
                if (hold_req) begin
                    next_r.st = S_HOLD;
                end else if (accept) begin
                    next_r.st = S_ADDR;
                    next_r.write = I_REQ_WRITE;
                    next_r.space = I_REQ_SPACE;
                    next_r.addr = I_REQ_ADDR;
                    next_r.wdata = I_REQ_WDATA;
                    // Only space 3 follows the width pin; others run 16 bits
                    next_r.bus16 = (I_REQ_SPACE != SPACE_BYTE_PIN) || !r.width_sy[1];
                    next_r.wide = I_REQ_WORD && !I_REQ_ADDR[0] &&
                                  ((I_REQ_SPACE != SPACE_BYTE_PIN) || !r.width_sy[1]);
                end
            end
            S_ADDR: begin
                if (tick) begin
                    next_r.st = S_STROBE;
                end
            end
            S_STROBE: begin
                // One ready sample per bus clock, low adds one clock
                if (tick && !rdy_low) begin
                    next_r.st = S_END;
                end
            end
            S_END: begin
                // Data taken a clock late: the pin synchroniser lags the strobe by two edges
                if (!tick && !r.write) begin
                    next_r.rvalid = 1'b1;
                    if (r.bus16 && odd && !r.wide) begin
                        next_r.rdata = {8'h00, r.din[15:8]};
                    end else if (r.wide) begin
                        next_r.rdata = r.din;
                    end else begin
                        next_r.rdata = {8'h00, r.din[7:0]};
                    end
                end
                if (tick) begin
                    next_r.st = S_IDLE;
                end
            end
            S_HOLD: begin
                if (!hold_req) begin
                    next_r.st = S_IDLE;
                end
            end
            default: next_r.st = S_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            r <= '0;
            r.st <= S_IDLE;
            r.hold_sy <= 2'h3;
            r.rdy_sy <= 2'h3;
        end else begin
            r <= next_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    logic busy;
    logic strobe;
    logic lo_lane;
    logic hi_lane;
    assign busy = (r.st == S_ADDR) || (r.st == S_STROBE) || (r.st == S_END);
    assign strobe = (r.st == S_STROBE);
    assign lo_lane = !r.bus16 || r.wide || !odd;
    assign hi_lane = r.bus16 && (r.wide || odd);

    always_comb begin
        O_ADDR = {~r.addr[23], r.addr[22:0]};
        O_ADDR_OE = (r.st != S_HOLD);
        O_CTRL_OE = (r.st != S_HOLD);
        O_BUS_GRANT_ACK_N = (r.st != S_HOLD);
        O_ALE = (r.st == S_ADDR) && !tick;
        O_SPACE_SELECT_N = 4'hF;
        if (busy) begin
            O_SPACE_SELECT_N[r.space] = 1'b0;
        end
        O_RD_N = !(strobe && !r.write);
        if (I_SINGLE_STROBE) begin
            O_LOW_BYTE_WRITE_N = !(strobe && r.write);
            O_HIGH_BYTE_WRITE_N = !(busy && hi_lane);
        end else begin
            O_LOW_BYTE_WRITE_N = !(strobe && r.write && lo_lane);
            O_HIGH_BYTE_WRITE_N = !(strobe && r.write && hi_lane);
        end
        O_DATA = (r.bus16 && odd && !r.wide) ? {r.wdata[7:0], 8'h00} : r.wdata;
        O_DATA_LO_OE = busy && r.write && lo_lane;
        O_DATA_HI_OE = busy && r.write && hi_lane;
        if (I_MUX_BUS && r.st == S_ADDR) begin
            O_DATA = r.bus16 ? r.addr[15:0] : {8'h00, r.addr[7:0]};
            O_DATA_LO_OE = 1'b1;
            O_DATA_HI_OE = r.bus16;
        end
        O_RDATA = r.rdata;
        O_RDATA_VALID = r.rvalid;
        O_MICROPROC_MODE = r.mode;
        O_DIVIDED_CLOCK_OUT = r.clk_out;
    end

////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    sequence s_hold_seen;
        (r.st == S_IDLE) && hold_req;
    endsequence
    property p_hold_enter;
        s_hold_seen |=> !O_BUS_GRANT_ACK_N;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("hold not entered");
    property p_ack_float;
        !O_BUS_GRANT_ACK_N |-> !O_ADDR_OE && !O_CTRL_OE && !O_DATA_LO_OE && !O_DATA_HI_OE;
    endproperty
    a_ack_float: assert property (p_ack_float) else $error("pins driven in hold");
    property p_hold_stay;
        !O_BUS_GRANT_ACK_N && hold_req |=> !O_BUS_GRANT_ACK_N;
    endproperty
    a_hold_stay: assert property (p_hold_stay) else $error("hold left early");
    property p_wait;
        strobe && tick && rdy_low |=> strobe;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state lost");
    sequence s_take;
        accept;
    endsequence
    property p_ale;
        s_take |=> O_ALE ##1 !O_ALE [*2] ##1 (O_RD_N == r.write);
    endproperty
    a_ale: assert property (p_ale) else $error("address phase wrong");
    property p_split_odd;
        !I_SINGLE_STROBE && strobe && r.write && r.bus16 && odd |-> !O_HIGH_BYTE_WRITE_N && O_LOW_BYTE_WRITE_N;
    endproperty
    a_split_odd: assert property (p_split_odd) else $error("odd write strobe");
    property p_read_float;
        !O_RD_N |-> !O_DATA_LO_OE && !O_DATA_HI_OE && (O_SPACE_SELECT_N[r.space] == 1'b0);
    endproperty
    a_read_float: assert property (p_read_float) else $error("drive during read");
    property p_addr_inv;
        O_ADDR[23] == !$past(O_ADDR[23], 1) |-> $past(accept, 1);
    endproperty
    a_addr_inv: assert property (p_addr_inv) else $error("address changed outside accept");
endmodule : ebi_top

/* File: verification/ebi_mem_model.sv */
// Purpose: External byte memory standing on the far side of the bus pins.
// Assumes: 256 cells, decoded from the low address byte only.
// Notes: Released data lines show the inverse of the last read value.
`timescale 1ns/1ns
module ebi_mem_model (
    input wire logic clk,
    input wire logic [23:0] addr,
    input wire logic [15:0] dout,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wl_n,
    input wire logic wh_n,
    input wire logic single,
    input wire logic mux,
    input wire logic bus8,
    input wire logic [3:0] stall,
    input wire logic [3:0] sel_n,
    output logic [15:0] din,
    output logic rdy_n
);
    logic [7:0] mem [256];
    logic [7:0] a = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic [15:0] last = 16'h0000;
    wire [7:0] ea = mux ? a : addr[7:0];
    // Stretch starts at select, so the request beats the pin synchroniser
    wire act = (sel_n != 4'hF);
    initial rdy_n = 1'b1;
    always @(posedge clk) begin
        if (ale && mux) a <= dout[7:0];
        rdy_n <= !(act && cnt < stall);
        cnt <= act ? cnt + ((cnt < stall) ? 4'h1 : 4'h0) : 4'h0;
        if (!rd_n) last <= din;
        if (!wl_n && bus8) mem[ea] <= dout[7:0];
        else begin
            if (!wl_n && (!single || !ea[0])) mem[{ea[7:1], 1'b0}] <= dout[7:0];
            if (single ? (!wl_n && !wh_n) : !wh_n) mem[{ea[7:1], 1'b1}] <= dout[15:8];
        end
    end
    // Lines float when not read; inverse value keeps stale data from passing
    always_comb begin
        if (!rd_n) din = bus8 ? {~last[15:8], mem[ea]} : {mem[{ea[7:1], 1'b1}], mem[{ea[7:1], 1'b0}]};
        else din = ~last;
    end
endmodule : ebi_mem_model

/* File: verification/external_memory_bus_interface_tb.sv */
// Purpose: Self-checking bench for the external bus interface.
// Assumes: Inputs change at the falling clock edge.
// Notes: Ordinary accesses come from a row table.
`timescale 1ns/1ns
module external_memory_bus_interface_tb;
    import ebi_pkg::*;
    typedef struct packed {logic [5:0] cfg; logic [23:0] addr; logic [15:0] d;} ebi_row_t;
    logic clk = 0, rstn = 0, valid = 0, wr = 0, word = 0, mux = 0, single = 0, w8 = 0, strap = 1, hold_n = 1, fc = 0;
    logic [1:0] sp = 0, csel = 0;
    logic [23:0] addr = 0, oaddr, seen_addr;
    logic [15:0] wdata = 0, rdata, din, dout, ale_data, rd;
    logic [3:0] stall = 0, sel, seen_sel, exp_sel;
    logic prev_cko;
    logic rdy, rv, mode, dlo, dhi, aoe, ale, rd_n, wl_n, wh_n, coe, ack_n, cko, rdy_n, lo_s, hi_s, rd_s, we, b8;
    int n_errors = 0, total_checks = 0, lat0, lat1, ed;
    int rise_exp [4] = '{96 >> (DIV_BCLK_BIT + 1), 96 / 6, 96 >> (DIV_F8_BIT + 1), 96 >> (DIV_F32_BIT + 1)};
    ebi_row_t rows [9] = '{'{6'h01, 24'h800010, 16'hA55A}, '{6'h02, 24'h000013, 16'h00C3},
        '{6'h14, 24'h800020, 16'h003C}, '{6'h10, 24'h000021, 16'h0096}, '{6'h23, 24'h000030, 16'h1E87},
        '{6'h34, 24'h800035, 16'h0069}, '{6'h1E, 24'h000041, 16'h00D2}, '{6'h3F, 24'h800044, 16'h4BE1},
        '{6'h27, 24'h000050, 16'h7788}};
    ebi_top dut_u (.I_CLK(clk), .I_RESETN(rstn), .I_REQ_VALID(valid), .I_REQ_WRITE(wr), .I_REQ_WORD(word),
        .I_REQ_SPACE(sp), .I_REQ_ADDR(addr), .I_REQ_WDATA(wdata), .O_REQ_READY(rdy), .O_RDATA(rdata),
        .O_RDATA_VALID(rv), .I_MUX_BUS(mux), .I_SINGLE_STROBE(single), .I_CLK_OUT_SEL(csel), .I_WIDTH_SEL(w8),
        .I_BOOT_MODE_STRAP(strap), .O_MICROPROC_MODE(mode), .I_FC_CLK(fc), .I_HOLD_N(hold_n), .I_READY_N(rdy_n),
        .I_DATA(din), .O_DATA(dout), .O_DATA_LO_OE(dlo), .O_DATA_HI_OE(dhi), .O_ADDR(oaddr), .O_ADDR_OE(aoe),
        .O_SPACE_SELECT_N(sel), .O_ALE(ale), .O_RD_N(rd_n), .O_LOW_BYTE_WRITE_N(wl_n),
        .O_HIGH_BYTE_WRITE_N(wh_n), .O_CTRL_OE(coe), .O_BUS_GRANT_ACK_N(ack_n), .O_DIVIDED_CLOCK_OUT(cko));
    ebi_mem_model mem_u (.clk(clk), .addr(oaddr), .dout(dout), .ale(ale), .rd_n(rd_n | !coe), .wl_n(wl_n | !coe),
        .wh_n(wh_n | !coe), .single(single), .mux(mux), .bus8(!sel[3] && w8), .stall(stall), .din(din),
        .sel_n(sel), .rdy_n(rdy_n));
    initial forever #4 clk = ~clk;
    always begin
        repeat (3) @(negedge clk);
        fc = ~fc;
    end
    always @(negedge clk) begin
        if (sel != 4'hF) seen_sel = sel;
        if (sel != 4'hF) seen_addr = oaddr;
        if (ale) ale_data = dout;
        if (!rd_n) rd_s = 1;
        if (!wl_n) lo_s = 1;
        if (!wh_n) hi_s = 1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] d, output int lat);
        lo_s = 0; hi_s = 0; rd_s = 0; lat = 0;
        while (rdy !== 1'b1 && lat < 60) begin
            @(negedge clk);
            lat++;
        end
        wr = w; wdata = d; valid = 1; lat = 0;
        @(negedge clk);
        valid = 0;
        while ((w ? rdy : rv) !== 1'b1 && lat < 60) begin
            @(negedge clk);
            lat++;
        end
        rd = rdata;
        if (lat == 60) chk("handshake", 0, 1);
    endtask : acc
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 6000);
        n_errors++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk);
        chk("reset outputs", 24'hFF, {ack_n, rd_n, wl_n, wh_n, sel});
        rstn = 1;
        acc(0, 0, lat0);
        chk("boot mode high", 1, mode);
        for (int i = 0; i < 9; i++) begin
            {mux, single, w8, sp, word} = rows[i].cfg;
            addr = rows[i].addr;
            b8 = sp == 2'h3 && w8;
            we = word && !addr[0] && !b8;
            exp_sel = ~(4'h1 << sp);
            repeat (3) @(negedge clk);
            acc(1, rows[i].d, lat0);
            chk("space select", exp_sel, seen_sel);
            if (!mux) chk("address", {~addr[23], addr[22:0]}, seen_addr);
            if (mux) chk("mux address", b8 ? addr[7:0] : addr[15:0], b8 ? ale_data[7:0] : ale_data);
            chk("write strobes", {single | !addr[0] | b8, !b8 & (addr[0] | we)}, {lo_s, hi_s});
            acc(0, 0, lat0);
            chk("read strobe", 1, rd_s);
            chk("read data", we ? rows[i].d : rows[i].d[7:0], we ? rd : rd[7:0]);
        end
        $display("Row table done");
        stall = 6;
        acc(0, 0, lat1);
        chk("wait stretch", 1, lat1 >= lat0 + 4);
        chk("stretched data", rows[8].d, rd);
        stall = 0;
        $display("Wait test done");
        hold_n = 0;
        repeat (6) @(negedge clk);
        chk("hold state", 0, {ack_n, aoe, coe, dlo, dhi, rdy});
        repeat (20) @(negedge clk);
        chk("hold kept", 0, {ack_n, aoe, coe, dlo, dhi, rdy});
        hold_n = 1;
        repeat (6) @(negedge clk);
        chk("hold left", 24'h7, {ack_n, aoe, coe});
        $display("Hold test done");
        for (int s = 0; s < 4; s++) begin
            csel = s[1:0];
            ed = 0;
            repeat (8) @(negedge clk);
            prev_cko = cko;
            repeat (96) begin
                @(negedge clk);
                if (cko && !prev_cko) ed++;
                prev_cko = cko;
            end
            chk("clock out", rise_exp[s], ed);
        end
        $display("Clock test done");
        rstn = 0;
        strap = 0;
        repeat (8) @(negedge clk);
        rstn = 1;
        acc(0, 0, lat0);
        chk("boot mode low", 0, mode);
        $display("Second reset done");
        close_out();
    end
endmodule : external_memory_bus_interface_tb
